/* File: verilog/tos_pkg.sv */
package tos_pkg;
	localparam int ADR_W = 6;
	localparam logic [5:0] OFS_ARM = 6'h00;
	localparam logic [5:0] OFS_TARGET = 6'h04;
	localparam logic [5:0] OFS_TIME_LO = 6'h08;
	localparam logic [5:0] OFS_TIME_HI = 6'h0C;
	localparam logic [5:0] OFS_CFG = 6'h10;
	localparam logic [5:0] OFS_STATUS = 6'h14;
	localparam logic [5:0] OFS_FEEDBACK = 6'h18;
	localparam logic [5:0] OFS_RB_LO = 6'h1C;
	localparam logic [5:0] OFS_RB_HI = 6'h20;
	localparam logic [7:0] ARM_IDLE = 8'h00;
	localparam logic [7:0] ARM_GO = 8'h03;
	localparam logic [15:0] READBACK_OBJ = 16'h1A00;
	localparam int CFG_FB_BIT = 16;
	localparam int ST_ARMED_BIT = 0;
	localparam int ST_RB_BIT = 1;
	localparam int ST_FB_BIT = 2;
	localparam int ST_WKC_LSB = 8;
	localparam int TGT_LVL1 = 0;
	localparam int TGT_TRI1 = 1;
	localparam int TGT_LVL2 = 2;
	localparam int TGT_TRI2 = 3;
	localparam logic [3:0] TARGET_RST = 4'h0;
	localparam logic [3:0] OUT_RST = 4'hA;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TIME_RES_NS = 1;
	localparam logic [63:0] TIME_STEP = 64'(CLK_PERIOD_NS / TIME_RES_NS);
endpackage

/* File: verilog/tos_time_if.sv */
`timescale 1ns/1ns
interface tos_time_if;
	logic [63:0] now;
	logic [63:0] switch_time;
	logic armed;
	logic hit;
	logic load;
	logic [63:0] load_value;
	modport base (
		output now,
		output hit,
		input switch_time,
		input armed,
		input load,
		input load_value
	);
	modport ctrl (
		input now,
		input hit,
		output switch_time,
		output armed,
		output load,
		output load_value
	);
endinterface

/* File: verilog/tos_time_base.sv */
`timescale 1ns/1ns
module tos_time_base
	import tos_pkg::*;
#(
	parameter logic [63:0] STEP = TIME_STEP
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// time and compare
	tos_time_if.base tb
);
	logic [63:0] count;
	logic [63:0] since;
	logic reached;

	// a zero step would freeze the local time and never match
	if (STEP == 64'h0) begin : g_step_check
		$error("time step must be at least one");
	end

	// ns count, one clock adds one period
	always_ff @(posedge clk) begin
		if (reset)
			count <= 64'h0;
		else if (tb.load)
			count <= tb.load_value;
		else
			count <= count + STEP; // RULE_03
	end

	// the count steps by a period, so exact equality could be skipped:
	// a hit is the one tick whose span holds the switch time
	assign since = count - tb.switch_time;
	assign reached = (count >= tb.switch_time) && (since < STEP);
	assign tb.hit = tb.armed && reached && !tb.load; // RULE_01 RULE_11
	assign tb.now = count;

	AST_TIME_STEP: assert property (@(posedge clk) disable iff (reset) // RULE_03
		!$past(tb.load) && !$past(reset) |-> count == $past(count) + STEP)
		else $error("local time did not advance by one step");
endmodule

/* File: verilog/tos_scheduler.sv */
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// RULE_01 - fire trigger immediately when time matches
// RULE_02 - trigger fires once per arming, applies targets
// RULE_03 - local time: 64-bit nanoseconds since 2000
// RULE_04 - master sends time, targets, arm zero
// RULE_05 - next cycle master writes arm three
// RULE_06 - arm only on arm byte zero-to-three
// RULE_07 - master holds arm and targets until switch
// RULE_08 - power loss discards pending switch time
// RULE_09 - one pending event, all four bits
// RULE_10 - at most one event per bus cycle
// RULE_11 - no cancel; new arming replaces pending
// RULE_12 - feedback byte: level1, tri1, level2, tri2
// RULE_13 - level bit drives, tristate bit releases
// RULE_14 - optional readback of sampled local time
// RULE_15 - readback and feedback mutually exclusive
// RULE_16 - readback enabled by mapping object assignment
// RULE_17 - report processing state per datagram
// RULE_18 - master picks time two cycles ahead
// RULE_19 - outputs hold until trigger fires
module tos_scheduler
	import tos_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// bus cycle and power
	input wire logic cycle_strobe,
	input wire logic power_good,
	// clock synchronisation load
	input wire logic time_set,
	input wire logic [63:0] time_set_value,
	// channel pins
	output logic [1:0] ch_level,
	output logic [1:0] ch_oe,
	// status
	output logic time_match_pulse,
	output logic [7:0] working_counter_state
);
	tos_time_if tb ();

	logic [7:0] arm_byte;
	logic [3:0] target;
	logic [63:0] switch_time;
	logic [63:0] pend_time;
	logic [3:0] pend_target;
	logic armed;
	logic cycle_used;
	logic [3:0] out_state;
	logic [15:0] cfg_assign;
	logic cfg_feedback;
	logic [63:0] local_time_readback;
	logic [7:0] wkc_count;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// bus decode
	wire req = wb_cyc_i && wb_stb_i;
	wire wr_go = req && wb_we_i && wb_ack_o;
	wire wr_arm = wr_go && (wb_adr_i == OFS_ARM);
	wire wr_target = wr_go && (wb_adr_i == OFS_TARGET);
	wire wr_lo = wr_go && (wb_adr_i == OFS_TIME_LO);
	wire wr_hi = wr_go && (wb_adr_i == OFS_TIME_HI);
	wire wr_cfg = wr_go && (wb_adr_i == OFS_CFG);
	wire [31:0] arm_word = merge({24'h0, arm_byte}, wb_dat_i, wb_sel_i);
	wire [31:0] tgt_word = merge({28'h0, target}, wb_dat_i, wb_sel_i);
	wire [31:0] lo_word = merge(switch_time[31:0], wb_dat_i, wb_sel_i);
	wire [31:0] hi_word = merge(switch_time[63:32], wb_dat_i, wb_sel_i);
	wire [31:0] cfg_old = {15'h0, cfg_feedback, cfg_assign};
	wire [31:0] cfg_word = merge(cfg_old, wb_dat_i, wb_sel_i);
	wire rb_on = (cfg_assign == READBACK_OBJ); // RULE_16
	wire cfg_new_rb = (cfg_word[15:0] == READBACK_OBJ);
	// a write asking for both views at once is refused whole
	wire cfg_ok = !(cfg_word[CFG_FB_BIT] && cfg_new_rb); // RULE_15

	// arming: only the zero-to-three step counts, once per bus cycle,
	// and never while the supply is reported down
	wire arm_edge = wr_arm && (arm_byte == ARM_IDLE) && (arm_word[7:0] == ARM_GO); // RULE_06
	wire accept = arm_edge && !cycle_used && power_good; // RULE_10
	wire hit = tb.hit;
	wire next_armed = power_good && (accept || (armed && !hit)); // RULE_08 RULE_11 RULE_02
	wire next_cycle_used = accept || (cycle_used && !cycle_strobe); // RULE_10

	assign tb.switch_time = pend_time;
	assign tb.armed = armed;
	assign tb.load = time_set;
	assign tb.load_value = time_set_value;

	tos_time_base #(
		.STEP(TIME_STEP)
	) u_time (
		.clk(clk),
		.reset(reset),
		.tb(tb)
	);

	// register reads
	wire [3:0] fb_view = cfg_feedback ? out_state : 4'h0; // RULE_12
	wire [63:0] rb_view = rb_on ? local_time_readback : 64'h0; // RULE_14
	wire [31:0] status_word = {16'h0, wkc_count, 5'h0, cfg_feedback, rb_on, armed};
	wire [31:0] rd_word =
		(wb_adr_i == OFS_ARM) ? {24'h0, arm_byte} :
		(wb_adr_i == OFS_TARGET) ? {28'h0, target} :
		(wb_adr_i == OFS_TIME_LO) ? switch_time[31:0] :
		(wb_adr_i == OFS_TIME_HI) ? switch_time[63:32] :
		(wb_adr_i == OFS_CFG) ? cfg_old :
		(wb_adr_i == OFS_STATUS) ? status_word :
		(wb_adr_i == OFS_FEEDBACK) ? {28'h0, fb_view} :
		(wb_adr_i == OFS_RB_LO) ? rb_view[31:0] :
		(wb_adr_i == OFS_RB_HI) ? rb_view[63:32] : 32'h0;

	// one wait state; unmapped reads give zero and writes vanish
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= rd_word;
		end
	end

	// process-data registers
	always_ff @(posedge clk) begin
		if (reset) begin
			arm_byte <= ARM_IDLE;
			target <= TARGET_RST;
			switch_time <= 64'h0;
		end else begin
			if (wr_arm)
				arm_byte <= arm_word[7:0];
			if (wr_target)
				target <= tgt_word[3:0];
			if (wr_lo)
				switch_time[31:0] <= lo_word;
			if (wr_hi)
				switch_time[63:32] <= hi_word;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_assign <= 16'h0;
			cfg_feedback <= 1'b0;
		end else if (wr_cfg && cfg_ok) begin
			cfg_assign <= cfg_word[15:0];
			cfg_feedback <= cfg_word[CFG_FB_BIT];
		end
	end

	// the single pending event; targets are taken with the arming,
	// so later target writes stay off the pins until a new arming takes them
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_time <= 64'h0;
			pend_target <= TARGET_RST;
			armed <= 1'b0;
			cycle_used <= 1'b0;
		end else begin
			if (accept) begin
				pend_time <= switch_time; // RULE_11
				pend_target <= target; // RULE_09 RULE_19
			end
			armed <= next_armed;
			cycle_used <= next_cycle_used;
		end
	end

	// outputs move only on the trigger, all four bits at once
	always_ff @(posedge clk) begin
		if (reset) begin
			out_state <= OUT_RST;
			ch_level <= {OUT_RST[TGT_LVL2], OUT_RST[TGT_LVL1]};
			ch_oe <= ~{OUT_RST[TGT_TRI2], OUT_RST[TGT_TRI1]};
			time_match_pulse <= 1'b0;
		end else begin
			time_match_pulse <= hit; // RULE_01 RULE_02
			if (hit) begin
				out_state <= pend_target; // RULE_09
				ch_level <= {pend_target[TGT_LVL2], pend_target[TGT_LVL1]}; // RULE_13
				ch_oe <= ~{pend_target[TGT_TRI2], pend_target[TGT_TRI1]}; // RULE_13
			end
		end
	end

	// time sampled at each bus cycle boundary; it is stale by the
	// time software reads it, so use only as a coarse reference
	always_ff @(posedge clk) begin
		if (reset)
			local_time_readback <= 64'h0;
		else if (cycle_strobe && rb_on)
			local_time_readback <= tb.now; // RULE_14
	end

	// accesses counted per bus cycle, reported at its end
	always_ff @(posedge clk) begin
		if (reset) begin
			wkc_count <= 8'h0;
			working_counter_state <= 8'h0;
		end else if (cycle_strobe) begin
			working_counter_state <= wkc_count; // RULE_17
			wkc_count <= {7'h0, wr_go || (req && wb_ack_o)};
		end else if (req && wb_ack_o) begin
			wkc_count <= wkc_count + 8'h01; // RULE_17
		end
	end

	sequence s_armed;
		$rose(armed);
	endsequence

	sequence s_fire;
		time_match_pulse ##1 !time_match_pulse;
	endsequence

	// after an accept, none the next cycle; one the cycle after may only follow a bus cycle mark
	sequence s_no_second;
		!accept ##1 (!accept || $past(cycle_strobe));
	endsequence

	AST_FIRE_ON_MATCH: assert property (@(posedge clk) disable iff (reset) // RULE_01
		hit |=> s_fire)
		else $error("match did not give a single trigger pulse");

	AST_ONE_SHOT: assert property (@(posedge clk) disable iff (reset) // RULE_02
		time_match_pulse && !$past(accept) |-> !armed)
		else $error("event still armed after firing");

	AST_ARM_EDGE: assert property (@(posedge clk) disable iff (reset) // RULE_06
		s_armed |-> $past(arm_byte) == ARM_IDLE && arm_byte == ARM_GO)
		else $error("armed without arm byte going zero to three");

	AST_POWER_LOSS: assert property (@(posedge clk) disable iff (reset) // RULE_08
		!power_good |=> !armed ##1 !time_match_pulse)
		else $error("pending event survived power loss");

	AST_APPLY_ALL: assert property (@(posedge clk) disable iff (reset) // RULE_09
		time_match_pulse |-> out_state == $past(pend_target)
			&& ch_level == {out_state[TGT_LVL2], out_state[TGT_LVL1]})
		else $error("trigger did not apply all target bits");

	AST_ONE_PER_CYCLE: assert property (@(posedge clk) disable iff (reset) // RULE_10
		accept |=> s_no_second)
		else $error("second event accepted in one bus cycle");

	AST_TRISTATE: assert property (@(posedge clk) disable iff (reset) // RULE_13
		ch_oe == ~{out_state[TGT_TRI2], out_state[TGT_TRI1]})
		else $error("output enable disagrees with tristate bit");

	AST_EXCLUSIVE: assert property (@(posedge clk) disable iff (reset) // RULE_15
		!(cfg_feedback && rb_on))
		else $error("feedback and readback both enabled");

	AST_HOLD: assert property (@(posedge clk) disable iff (reset) // RULE_19
		!hit && !$past(reset) |=> $stable(ch_level) && $stable(ch_oe))
		else $error("outputs moved without a trigger");

	AST_MATCH_EXACT: assert property (@(posedge clk) disable iff (reset) // RULE_01
		armed && tb.now == pend_time && !time_set |-> hit)
		else $error("exact time match did not raise the trigger");

	AST_LOAD_TIME: assert property (@(posedge clk) disable iff (reset) // RULE_03
		time_set |=> tb.now == $past(time_set_value))
		else $error("local time not loaded from the set value");

	AST_REARM_REPLACES: assert property (@(posedge clk) disable iff (reset) // RULE_11
		accept |=> armed && pend_time == $past(switch_time))
		else $error("new arming did not replace the pending event");

	AST_FEEDBACK_PINS: assert property (@(posedge clk) disable iff (reset) // RULE_12
		cfg_feedback |-> fb_view == {~ch_oe[1], ch_level[1], ~ch_oe[0], ch_level[0]})
		else $error("feedback byte disagrees with the pins");

	AST_READBACK_SAMPLE: assert property (@(posedge clk) disable iff (reset) // RULE_14
		cycle_strobe && rb_on |=> local_time_readback == $past(tb.now))
		else $error("readback not sampled at the bus cycle mark");

	AST_CFG_REFUSED: assert property (@(posedge clk) disable iff (reset) // RULE_15
		wr_cfg && !cfg_ok |=> $stable(cfg_assign) && $stable(cfg_feedback))
		else $error("conflicting configuration write was taken");

	AST_WKC_REPORT: assert property (@(posedge clk) disable iff (reset) // RULE_17
		cycle_strobe |=> working_counter_state == $past(wkc_count))
		else $error("access count not reported at the bus cycle mark");

	AST_TARGET_KEPT: assert property (@(posedge clk) disable iff (reset) // RULE_19
		!accept |=> $stable(pend_target))
		else $error("pending targets changed without an arming");
endmodule

/* File: tb/tos_master_model.sv */
`timescale 1ns/1ns
// fieldbus master: register access and bus cycle marks
module tos_master_model
	import tos_pkg::*;
(
	// clock
	input wire logic clk,
	// wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [ADR_W-1:0] adr,
	output logic [31:0] dat,
	output logic [3:0] sel,
	input wire logic [31:0] dat_i,
	input wire logic ack,
	// bus cycle mark
	output logic cycle_strobe
);
	initial begin
		{cyc, stb, we, adr, dat, sel, cycle_strobe} = '0;
	end
	// request held until ack is sampled; latency not assumed
	task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_i;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [ADR_W-1:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
	// single pulse per bus cycle, so one event at most each
	task automatic strobe();
		@(posedge clk);
		cycle_strobe <= 1'b1;
		@(posedge clk);
		cycle_strobe <= 1'b0;
	endtask
	task automatic arm(input logic [63:0] t, input logic [3:0] tg);
		wr(OFS_TIME_LO, t[31:0]);
		wr(OFS_TIME_HI, t[63:32]);
		wr(OFS_TARGET, {28'h0, tg});
		wr(OFS_ARM, {24'h0, ARM_IDLE});
		strobe();
		wr(OFS_ARM, {24'h0, ARM_GO});
	endtask
endmodule

/* File: tb/tb_timestamped_output_scheduler.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_timestamped_output_scheduler
	import tos_pkg::*;
;
	logic clk, reset, power_good, time_set, cyc, stb, we, cstr, ack, pulse, seen;
	logic [63:0] tsv;
	logic [ADR_W-1:0] adr;
	logic [31:0] dat, dat_o, q;
	logic [3:0] sel;
	logic [1:0] lvl, oe;
	logic [7:0] wcs;
	int err_count, n_checks, cyc_cnt;
	tos_master_model m (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(dat),
		.sel(sel), .dat_i(dat_o), .ack(ack), .cycle_strobe(cstr));
	tos_scheduler dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .cycle_strobe(cstr), .power_good(power_good), .time_set(time_set),
		.time_set_value(tsv), .ch_level(lvl), .ch_oe(oe), .time_match_pulse(pulse),
		.working_counter_state(wcs));
	always #5 clk = ~clk;
	task automatic summarize();
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_count++;
			summarize();
		end
	end
	task automatic tset(input logic [63:0] v);
		@(posedge clk);
		tsv <= v;
		time_set <= 1'b1;
		@(posedge clk);
		time_set <= 1'b0;
	endtask
	task automatic wait_pulse(input int n);
		seen = 1'b0;
		for (int i = 0; i < n && seen !== 1'b1; i++) begin
			@(posedge clk);
			seen = pulse;
		end
	endtask
	task automatic armed(input logic e);
		m.rd(OFS_STATUS, q);
		`CHK(q[ST_ARMED_BIT], e)
	endtask
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		power_good = 1'b1;
		time_set = 1'b0;
		tsv = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK({lvl, oe}, 4'h0)
		armed(1'b0);
		m.rd(OFS_RB_LO, q);
		`CHK(q, 32'h0)
		tset(64'h1_0000_0000);
		m.wr(OFS_CFG, 32'h0001_1A00);
		m.rd(OFS_STATUS, q);
		`CHK(q[ST_FB_BIT:ST_RB_BIT], 2'b00)
		m.wr(OFS_CFG, {16'h0, READBACK_OBJ});
		m.strobe();
		m.rd(OFS_RB_HI, q);
		`CHK(q, 32'h1)
		m.rd(OFS_FEEDBACK, q);
		`CHK(q, 32'h0)
		m.wr(OFS_CFG, 32'h0001_0000);
		m.rd(OFS_RB_HI, q);
		`CHK(q, 32'h0)
		// exactly three acked accesses between two marks
		m.strobe();
		repeat (3) m.rd(OFS_STATUS, q);
		m.strobe();
		repeat (2) @(posedge clk);
		`CHK(wcs, 8'h03)
		// time chosen well ahead of the arm sequence
		tset(64'h2_0000_0000);
		m.arm(64'h2_0000_0000 + 64'd3000, 4'h5);
		armed(1'b1);
		m.wr(OFS_TARGET, 32'hA);
		`CHK(oe, 2'b00)
		wait_pulse(600);
		`CHK(seen, 1'b1)
		`CHK({lvl, oe}, 4'hF)
		@(posedge clk);
		`CHK(pulse, 1'b0)
		m.rd(OFS_FEEDBACK, q);
		`CHK(q[3:0], 4'h5)
		wait_pulse(400);
		`CHK(seen, 1'b0)
		// repeated three and zero-to-one must not arm
		tset(64'h3_0000_0000);
		m.wr(OFS_TIME_LO, 32'd3000);
		m.wr(OFS_ARM, {24'h0, ARM_GO});
		armed(1'b0);
		m.wr(OFS_ARM, 32'h0);
		m.strobe();
		m.wr(OFS_ARM, 32'h1);
		armed(1'b0);
		m.arm(64'h3_0000_0000 + 64'd3000, 4'hA);
		armed(1'b1);
		@(posedge clk);
		power_good <= 1'b0;
		@(posedge clk);
		power_good <= 1'b1;
		armed(1'b0);
		wait_pulse(400);
		`CHK(seen, 1'b0)
		// past time replaces a pending event that would fire
		tset(64'h4_0000_0000);
		m.arm(64'h4_0000_0000 + 64'd2500, 4'hA);
		m.arm(64'h3_0000_0000, 4'hA);
		wait_pulse(400);
		`CHK(seen, 1'b0)
		`CHK({lvl, oe}, 4'hF)
		// a second arming before the next mark is refused
		m.wr(OFS_ARM, {24'h0, ARM_IDLE});
		m.wr(OFS_TIME_HI, 32'h4);
		m.wr(OFS_TIME_LO, 32'd8000);
		m.wr(OFS_ARM, {24'h0, ARM_GO});
		wait_pulse(400);
		`CHK(seen, 1'b0)
		summarize();
	end
endmodule
